// ==== hdl/rtc_calendar_date_year_control.sv ====
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_defs.svh"

// Notes on behaviour
// - Date is two BCD digits, 01 to 31, low 0-9, high 0-3.
// - Date steps once on each day carry from the hour counter.
// - Date follows real month lengths, leap February, years 2000 to 2099.
// - Month is BCD 01 to 12, four-bit low digit, one-bit high digit.
// - Month steps on the date's end-of-month carry.
// - Year is BCD 00 to 99; the century is fixed at 20.
// - Year steps on the month's end-of-year carry.
// - Bit 0 picks automatic correction; change only while not busy.
// - Bit 1 enables the clock output pin; change only while stopped.
// - Read-only bit 2 is one for year 00 or multiples of four.
// - Writing one to bit 4 soft-resets; software then writes it back to zero.
// - Soft reset clears run, mode, p.m., correction; sets leap; keeps bits 1, 3, 4.
// - After soft reset year is 00, leap is one, date and month 01.
// - Bit 5 is zero for a.m., one for p.m., used in 12-hour mode.
// - In 12-hour counting p.m. toggles on the 11:59:59 rollover.
// - Bit 6 selects 12-hour or 24-hour counting; change only while stopped.
// - Bit 7 zero stops the counters, one runs them.
// - The busy flag is one while calendar data or p.m. bit update.
module rtc_calendar_date_year_control
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       write_protect_release,
  input  wire logic       day_carry,
  input  wire logic       half_day_rollover,
  input  wire logic       clock_source,
  output logic            run_count,
  output logic            twentyfour_hour_sel,
  output logic            afternoon_flag,
  output logic            auto_correct_enable,
  output logic            calendar_soft_reset,
  output logic            update_busy_flag,
  output logic            year_carry,
  output logic            clock_output_pin
);

  rtc_cal_pkg::bcd_date_t  date_value;
  rtc_cal_pkg::bcd_month_t month_value;
  rtc_cal_pkg::bcd_year_t  year_value;
  rtc_cal_pkg::bcd_date_t  last_day;
  logic                    date_carry;
  logic                    month_carry;
  logic                    year_wrap;
  logic                    leap;
  logic                    run_q;
  logic                    twentyfour_hour_sel_q;
  logic                    pm_q;
  logic                    aadj_q;
  logic                    out_en_q;
  logic                    zero_bit_q;
  logic                    soft_q;
  logic                    next_run;
  logic                    next_twentyfour_hour_sel;
  logic                    next_pm;
  logic                    next_aadj;
  logic                    next_out_en;
  logic                    next_zero_bit;
  logic                    next_soft;
  logic                    wr_date;
  logic                    wr_month;
  logic                    wr_year;
  logic                    wr_ctl;
  logic                    day_step;
  logic                    pm_toggle;
  rtc_cal_pkg::reg_byte_t  ctl_view;
  rtc_cal_pkg::reg_byte_t  next_rdata;

  // Protection is enforced here too, so a stray write cannot corrupt the date
  assign wr_date   = reg_wr && write_protect_release && (reg_addr == `CAL_DATE_OFS);
  assign wr_month  = reg_wr && write_protect_release && (reg_addr == `CAL_MONTH_OFS);
  assign wr_year   = reg_wr && write_protect_release && (reg_addr == `CAL_YEAR_OFS);
  assign wr_ctl    = reg_wr && (reg_addr == `CLOCK_CONTROL_OFS);
  assign day_step  = run_q && day_carry;
  assign pm_toggle = run_q && !twentyfour_hour_sel_q && half_day_rollover;

  // Year 00 counts as leap since 2000 is one
  assign leap = year_value[4] ? (year_value[3:0] == 4'h2 || year_value[3:0] == 4'h6)
                              : (year_value[3:0] == 4'h0 || year_value[3:0] == 4'h4 ||
                                 year_value[3:0] == 4'h8);

  month_days u_month_days
  (
    .month    (month_value),
    .leap     (leap),
    .last_day (last_day)
  );

  bcd_wrap_counter
  #(
    .WIDTH      (6),
    .INIT_VALUE (`DATE_FIRST)
  )
  u_date
  (
    .core_clk    (core_clk),
    .srst        (srst),
    .soft_clear  (soft_q),
    .load        (wr_date),
    .load_value  (reg_wdata[5:0]),
    .step        (day_step),
    .first_value (`DATE_FIRST),
    .last_value  (last_day),
    .value       (date_value),
    .carry       (date_carry)
  );

  bcd_wrap_counter
  #(
    .WIDTH      (5),
    .INIT_VALUE (`MONTH_FIRST)
  )
  u_month
  (
    .core_clk    (core_clk),
    .srst        (srst),
    .soft_clear  (soft_q),
    .load        (wr_month),
    .load_value  (reg_wdata[4:0]),
    .step        (date_carry),
    .first_value (`MONTH_FIRST),
    .last_value  (`MONTH_LAST),
    .value       (month_value),
    .carry       (month_carry)
  );

  bcd_wrap_counter
  #(
    .WIDTH      (8),
    .INIT_VALUE (`YEAR_FIRST)
  )
  u_year
  (
    .core_clk    (core_clk),
    .srst        (srst),
    .soft_clear  (soft_q),
    .load        (wr_year),
    .load_value  (reg_wdata),
    .step        (month_carry),
    .first_value (`YEAR_FIRST),
    .last_value  (`YEAR_LAST),
    .value       (year_value),
    .carry       (year_wrap)
  );

  // Control register; soft reset acts on the edge after the bit is stored
  always_comb
  begin
    next_run      = run_q;
    next_twentyfour_hour_sel     = twentyfour_hour_sel_q;
    next_pm       = pm_q;
    next_aadj     = aadj_q;
    next_out_en   = out_en_q;
    next_zero_bit = zero_bit_q;
    next_soft     = soft_q;
    if (wr_ctl)
    begin
      next_run      = reg_wdata[`CTL_RUN_BIT];
      next_twentyfour_hour_sel     = reg_wdata[`CTL_TWENTYFOUR_HOUR_SEL_BIT];
      next_aadj     = reg_wdata[`CTL_AUTO_CORR_BIT];
      next_out_en   = reg_wdata[`CTL_OUT_EN_BIT];
      next_zero_bit = reg_wdata[`CTL_MUST_ZERO_BIT];
      next_soft     = reg_wdata[`CTL_SOFT_RST_BIT];
      if (write_protect_release)
        next_pm = reg_wdata[`CTL_PM_BIT];
    end
    if (pm_toggle)
      next_pm = !pm_q;
    // Held in reset while the bit stays set; output enable and bits 3, 4 survive
    if (soft_q)
    begin
      next_run  = 1'b0;
      next_twentyfour_hour_sel = 1'b0;
      next_pm   = 1'b0;
      next_aadj = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      run_q      <= 1'b0;
      twentyfour_hour_sel_q     <= 1'b0;
      pm_q       <= 1'b0;
      aadj_q     <= 1'b0;
      out_en_q   <= 1'b0;
      zero_bit_q <= 1'b0;
      soft_q     <= 1'b0;
    end
    else
    begin
      run_q      <= next_run;
      twentyfour_hour_sel_q     <= next_twentyfour_hour_sel;
      pm_q       <= next_pm;
      aadj_q     <= next_aadj;
      out_en_q   <= next_out_en;
      zero_bit_q <= next_zero_bit;
      soft_q     <= next_soft;
    end
  end

  always_comb
  begin
    ctl_view = 8'h00;
    ctl_view[`CTL_RUN_BIT]       = run_q;
    ctl_view[`CTL_TWENTYFOUR_HOUR_SEL_BIT]      = twentyfour_hour_sel_q;
    ctl_view[`CTL_PM_BIT]        = pm_q;
    ctl_view[`CTL_SOFT_RST_BIT]  = soft_q;
    ctl_view[`CTL_MUST_ZERO_BIT] = zero_bit_q;
    ctl_view[`CTL_LEAP_BIT]      = leap;
    ctl_view[`CTL_OUT_EN_BIT]    = out_en_q;
    ctl_view[`CTL_AUTO_CORR_BIT] = aadj_q;
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `CAL_DATE_OFS:      next_rdata = {2'b00, date_value} & `DATE_MASK;
        `CAL_MONTH_OFS:     next_rdata = {3'b000, month_value} & `MONTH_MASK;
        `CAL_YEAR_OFS:      next_rdata = year_value;
        `CLOCK_CONTROL_OFS: next_rdata = ctl_view;
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  // Outputs registered; busy marks the cycle right after a running day step or p.m. toggle, not a register load
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_rdata           <= 8'h00;
      update_busy_flag    <= 1'b0;
      year_carry          <= 1'b0;
      clock_output_pin    <= 1'b0;
      run_count           <= 1'b0;
      twentyfour_hour_sel <= 1'b0;
      afternoon_flag      <= 1'b0;
      auto_correct_enable <= 1'b0;
      calendar_soft_reset <= 1'b0;
    end
    else
    begin
      reg_rdata           <= next_rdata;
      update_busy_flag    <= day_step || pm_toggle;
      year_carry          <= year_wrap;
      clock_output_pin    <= out_en_q && clock_source;
      run_count           <= next_run;
      twentyfour_hour_sel <= next_twentyfour_hour_sel;
      afternoon_flag      <= next_pm;
      auto_correct_enable <= next_aadj;
      calendar_soft_reset <= next_soft;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/rtc_cal_defs.svh ====
`ifndef RTC_CAL_DEFS_SVH
`define RTC_CAL_DEFS_SVH

// Register offsets on the byte-wide register port
`define CAL_DATE_OFS        10'h114
`define CAL_MONTH_OFS       10'h115
`define CAL_YEAR_OFS        10'h116
`define CLOCK_CONTROL_OFS   10'h117

// Field layout of clock_control
`define CTL_AUTO_CORR_BIT   0
`define CTL_OUT_EN_BIT      1
`define CTL_LEAP_BIT        2
`define CTL_MUST_ZERO_BIT   3
`define CTL_SOFT_RST_BIT    4
`define CTL_PM_BIT          5
`define CTL_TWENTYFOUR_HOUR_SEL_BIT        6
`define CTL_RUN_BIT         7

// Field masks of the calendar registers
`define DATE_MASK           8'h3f
`define MONTH_MASK          8'h1f

// Counter limits and soft-reset values, all BCD
`define DATE_FIRST          6'h01
`define MONTH_FIRST         5'h01
`define MONTH_LAST          5'h12
`define YEAR_FIRST          8'h00
`define YEAR_LAST           8'h99
`define FEB_DAYS_COMMON     6'h28
`define FEB_DAYS_LEAP       6'h29
`define SHORT_MONTH_DAYS    6'h30
`define LONG_MONTH_DAYS     6'h31

`endif

// ==== hdl/rtc_cal_pkg.sv ====
`default_nettype none

package rtc_cal_pkg;
  typedef logic [7:0] bcd_year_t;
  typedef logic [4:0] bcd_month_t;
  typedef logic [5:0] bcd_date_t;
  typedef logic [7:0] reg_byte_t;
endpackage

`default_nettype wire

// ==== hdl/month_days.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_defs.svh"

module month_days
(
  input  wire logic [4:0] month,
  input  wire logic       leap,
  output logic      [5:0] last_day
);

  always_comb
  begin
    case (month)
      5'h02:   last_day = leap ? `FEB_DAYS_LEAP : `FEB_DAYS_COMMON;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   last_day = `SHORT_MONTH_DAYS;
      default: last_day = `LONG_MONTH_DAYS;
    endcase
  end

endmodule
`default_nettype wire

// ==== hdl/bcd_wrap_counter.sv ====
`timescale 1ns/1ns
`default_nettype none

// Two-digit BCD counter with a low digit of four bits and a high digit of WIDTH-4 bits
module bcd_wrap_counter
#(
  parameter int              WIDTH      = 8,
  parameter logic [WIDTH-1:0] INIT_VALUE = '0
)
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             soft_clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] first_value,
  input  wire logic [WIDTH-1:0] last_value,
  output logic      [WIDTH-1:0] value,
  output logic                  carry
);

  logic [WIDTH-1:0] next_value;
  logic [WIDTH-1:0] bumped;

  assign carry = step && (value == last_value);

  always_comb
  begin
    if (value[3:0] == 4'h9)
      bumped = {value[WIDTH-1:4] + 1'b1, 4'h0};
    else
      bumped = value + 1'b1;
    next_value = value;
    if (soft_clear)
      next_value = INIT_VALUE;
    else if (load)
      next_value = load_value;
    else if (step)
      next_value = (value == last_value) ? first_value : bumped;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      value <= INIT_VALUE;
    else
      value <= next_value;
  end

endmodule
`default_nettype wire

// ==== tb/rtc_cal_checker.sv ====
`timescale 1ns/1ns
`default_nettype none

module rtc_cal_checker
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       reg_wr,
  input wire logic       day_carry,
  input wire logic       half_day_rollover,
  input wire logic       clock_source,
  input wire logic       run_count,
  input wire logic       twentyfour_hour_sel,
  input wire logic       afternoon_flag,
  input wire logic       auto_correct_enable,
  input wire logic       calendar_soft_reset,
  input wire logic       update_busy_flag,
  input wire logic       year_carry,
  input wire logic       clock_output_pin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  step_busy_a: assert property (day_carry && run_count && !calendar_soft_reset |=> update_busy_flag)
    else $error("busy flag missing after a day step");
  stop_idle_a: assert property (!run_count && !reg_wr |=> !update_busy_flag)
    else $error("busy flag raised while stopped");
  pm_toggle_a: assert property (half_day_rollover && run_count && !twentyfour_hour_sel && !calendar_soft_reset
    |=> afternoon_flag != $past(afternoon_flag)) else $error("afternoon flag did not toggle");
  pm_hold_a: assert property (half_day_rollover && twentyfour_hour_sel && !reg_wr && !calendar_soft_reset
    |=> $stable(afternoon_flag)) else $error("afternoon flag moved in 24-hour mode");
  stop_pm_a: assert property (half_day_rollover && !run_count && !reg_wr && !calendar_soft_reset |=> $stable(afternoon_flag))
    else $error("afternoon flag moved while stopped");
  ctl_hold_a: assert property (!reg_wr && !calendar_soft_reset
    |=> $stable({run_count, twentyfour_hour_sel, auto_correct_enable})) else $error("control bit changed unwritten");
  soft_clear_a: assert property (calendar_soft_reset
    |=> !run_count && !twentyfour_hour_sel && !afternoon_flag && !auto_correct_enable)
    else $error("soft reset left a control bit set");
  oe_gate_a: assert property (clock_output_pin |-> $past(clock_source))
    else $error("clock output high without source");
  year_pulse_a: assert property (year_carry |=> !year_carry)
    else $error("year carry longer than one cycle");
endmodule

bind rtc_calendar_date_year_control rtc_cal_checker i_rtc_cal_checker
(
  .core_clk, .srst, .reg_wr, .day_carry, .half_day_rollover, .clock_source, .run_count,
  .twentyfour_hour_sel, .afternoon_flag, .auto_correct_enable, .calendar_soft_reset,
  .update_busy_flag, .year_carry, .clock_output_pin
);

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_defs.svh"

module tb;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       write_protect_release = 1'b0;
  logic       day_carry = 1'b0;
  logic       half_day_rollover = 1'b0;
  logic       clock_source = 1'b0;
  logic       run_count, twentyfour_hour_sel, afternoon_flag, auto_correct_enable;
  logic       calendar_soft_reset, update_busy_flag, year_carry, clock_output_pin;
  int         yc_count = 0;
  int         n_fail = 0;
  int         comparisons = 0;

  rtc_calendar_date_year_control i_rtc_calendar_date_year_control
  (
    .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .write_protect_release,
    .day_carry, .half_day_rollover, .clock_source, .run_count, .twentyfour_hour_sel, .afternoon_flag,
    .auto_correct_enable, .calendar_soft_reset, .update_busy_flag, .year_carry, .clock_output_pin
  );

  always #10 core_clk = ~core_clk;

  // Count carry pulses, so a stretched pulse shows up as a count above one
  always @(posedge core_clk)
    if (year_carry === 1'b1)
      yc_count <= yc_count + 1;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask

  task automatic day();
    @(posedge core_clk);
    day_carry <= 1'b1;
    @(posedge core_clk);
    day_carry <= 1'b0;
    #1;
  endtask

  task automatic half();
    @(posedge core_clk);
    half_day_rollover <= 1'b1;
    @(posedge core_clk);
    half_day_rollover <= 1'b0;
  endtask

  task automatic set_cal(input logic [7:0] d, input logic [7:0] m, input logic [7:0] y);
    wr(`CLOCK_CONTROL_OFS, 8'h00);
    wr(`CAL_DATE_OFS, d);
    wr(`CAL_MONTH_OFS, m);
    wr(`CAL_YEAR_OFS, y);
  endtask

  task automatic reset_vals();
    rd(`CAL_DATE_OFS, 8'h01, "date");
    rd(`CAL_MONTH_OFS, 8'h01, "month");
    rd(`CAL_YEAR_OFS, 8'h00, "year");
    rd(`CLOCK_CONTROL_OFS, 8'h04, "control");
    wr(10'h118, 8'hff);
    rd(10'h118, 8'h00, "unmapped");
  endtask

  task automatic protect();
    wr(`CAL_DATE_OFS, 8'h15);
    rd(`CAL_DATE_OFS, 8'h01, "locked date");
    @(posedge core_clk) write_protect_release <= 1'b1;
    wr(`CAL_DATE_OFS, 8'hff);
    rd(`CAL_DATE_OFS, 8'h3f, "date mask");
    wr(`CAL_MONTH_OFS, 8'hff);
    rd(`CAL_MONTH_OFS, 8'h1f, "month mask");
  endtask

  task automatic pm_mode();
    @(posedge core_clk) write_protect_release <= 1'b0;
    wr(`CLOCK_CONTROL_OFS, 8'h20);
    rd(`CLOCK_CONTROL_OFS, 8'h04, "locked pm");
    @(posedge core_clk) write_protect_release <= 1'b1;
    wr(`CLOCK_CONTROL_OFS, 8'h80);
    half();
    rd(`CLOCK_CONTROL_OFS, 8'ha4, "pm on");
    half();
    rd(`CLOCK_CONTROL_OFS, 8'h84, "pm off");
    // Mode and p.m. bit change only while stopped
    wr(`CLOCK_CONTROL_OFS, 8'h00);
    wr(`CLOCK_CONTROL_OFS, 8'h40);
    wr(`CLOCK_CONTROL_OFS, 8'hc0);
    half();
    rd(`CLOCK_CONTROL_OFS, 8'hc4, "pm 24h");
    chk("twentyfour_hour_sel", {7'h00, twentyfour_hour_sel}, 8'h01);
    wr(`CLOCK_CONTROL_OFS, 8'h40);
    wr(`CLOCK_CONTROL_OFS, 8'h20);
    #1 chk("pm out", {7'h00, afternoon_flag}, 8'h01);
  endtask

  task automatic ctl_bits();
    wr(`CLOCK_CONTROL_OFS, 8'h03);
    rd(`CLOCK_CONTROL_OFS, 8'h07, "control bits");
    chk("auto", {7'h00, auto_correct_enable}, 8'h01);
    @(posedge core_clk) clock_source <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("out on", {7'h00, clock_output_pin}, 8'h01);
    wr(`CLOCK_CONTROL_OFS, 8'h00);
    rd(`CLOCK_CONTROL_OFS, 8'h04, "leap kept");
    chk("out off", {7'h00, clock_output_pin}, 8'h00);
  endtask

  task automatic stopped();
    set_cal(8'h15, 8'h07, 8'h23);
    day();
    chk("busy stopped", {7'h00, update_busy_flag}, 8'h00);
    rd(`CAL_DATE_OFS, 8'h15, "held date");
    half();
    rd(`CLOCK_CONTROL_OFS, 8'h00, "held pm");
  endtask

  task automatic months();
    logic [7:0] mo [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12};
    logic [7:0] ln [12] = '{8'h31, 8'h28, 8'h31, 8'h30, 8'h31, 8'h30, 8'h31, 8'h31, 8'h30, 8'h31, 8'h30, 8'h31};
    int         idx;
    logic [7:0] yr, last, nyr;
    logic       lp;
    int         yc_base;
    for (int i = 0; i < 15; i++)
    begin
      idx = (i < 12) ? i : ((i == 14) ? 11 : 1);
      yr = (i < 12) ? 8'h23 : ((i == 12) ? 8'h24 : ((i == 13) ? 8'h00 : 8'h99));
      last = (i == 12 || i == 13) ? 8'h29 : ln[idx];
      lp = (yr == 8'h24 || yr == 8'h00);
      nyr = (idx != 11) ? yr : ((yr == 8'h99) ? 8'h00 : 8'h24);
      set_cal((last[3:0] == 4'h0) ? last - 8'h07 : last - 8'h01, mo[idx], yr);
      wr(`CLOCK_CONTROL_OFS, 8'h80);
      rd(`CLOCK_CONTROL_OFS, {5'b10000, lp, 2'b00}, "leap flag");
      chk("run", {7'h00, run_count}, 8'h01);
      day();
      chk("busy", {7'h00, update_busy_flag}, 8'h01);
      rd(`CAL_DATE_OFS, last, "last date");
      yc_base = yc_count;
      day();
      rd(`CAL_DATE_OFS, 8'h01, "wrapped date");
      rd(`CAL_MONTH_OFS, mo[(idx + 1) % 12], "next month");
      rd(`CAL_YEAR_OFS, nyr, "next year");
      chk("year carry", 8'(yc_count - yc_base), {7'h00, yr == 8'h99});
    end
  endtask

  task automatic soft_rst();
    set_cal(8'h15, 8'h07, 8'h23);
    wr(`CLOCK_CONTROL_OFS, 8'he3);
    wr(`CLOCK_CONTROL_OFS, 8'hf3);
    rd(`CAL_DATE_OFS, 8'h01, "soft date");
    rd(`CAL_MONTH_OFS, 8'h01, "soft month");
    rd(`CAL_YEAR_OFS, 8'h00, "soft year");
    rd(`CLOCK_CONTROL_OFS, 8'h16, "soft control");
    chk("soft out", {7'h00, calendar_soft_reset}, 8'h01);
    wr(`CLOCK_CONTROL_OFS, 8'h00);
    rd(`CLOCK_CONTROL_OFS, 8'h04, "released");
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    summarize();
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    reset_vals();
    protect();
    pm_mode();
    ctl_bits();
    stopped();
    months();
    soft_rst();
    summarize();
  end
endmodule

`default_nettype wire
